// ---- design/cgw_pkg.sv ----
// constants, register map and carrier types of the card guard and wait timers
package cgw_pkg;

  localparam int ADDR_W = 18;

  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_SPACING_MSB = 16'hfe16;
  localparam logic [15:0] IDX_SPACING_LOW = 16'hfe17;
  localparam logic [15:0] IDX_BLOCK_B3    = 16'hfe18;
  localparam logic [15:0] IDX_BLOCK_B2    = 16'hfe19;
  localparam logic [15:0] IDX_BLOCK_B1    = 16'hfe1a;
  localparam logic [15:0] IDX_BLOCK_B0    = 16'hfe1b;
  localparam logic [15:0] IDX_CHAR_HIGH   = 16'hfe1c;
  localparam logic [15:0] IDX_CHAR_LOW    = 16'hfe1d;
  localparam logic [15:0] IDX_ANSWER_HIGH = 16'hfe1f;
  localparam logic [15:0] IDX_ANSWER_LOW  = 16'hfe20;
  localparam logic [15:0] IDX_FIRST_LIMIT = 16'hfe21;
  localparam logic [15:0] IDX_RELEASE_DLY = 16'hfe22;
  localparam logic [15:0] IDX_CTRL        = 16'hfe30;
  localparam logic [15:0] IDX_STATUS      = 16'hfe31;
  localparam logic [15:0] IDX_MASK        = 16'hfe32;

  // field positions
  localparam int SPACING_MSB_BIT = 7;
  localparam int CTRL_T1_BIT     = 0;
  localparam int CTRL_ANSWER_BIT = 1;
  localparam int CTRL_DETECT_BIT = 2;
  localparam int CTRL_HOLD_BIT   = 7;
  localparam int ST_WAIT         = 0;
  localparam int ST_CHAR         = 1;
  localparam int ST_ANSWER       = 2;
  localparam int ST_W            = 3;

  // spacing floors in etus
  localparam logic [8:0] FLOOR_T0 = 9'h00c;
  localparam logic [8:0] FLOOR_T1 = 9'h00b;
  localparam logic [8:0] SPACE_SAT = 9'h1ff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [8:0]  spacing;
    logic [27:0] block_wait;
    logic [15:0] char_wait;
    logic [15:0] answer_limit;
    logic [7:0]  first_limit;
    logic [7:0]  release_dly;
    logic [7:0]  ctrl;
    logic [2:0]  mask;
  } cgw_cfg_s;

  // reset values
  localparam cgw_cfg_s CFG_RST = '{spacing: 9'h00c, block_wait: 28'h0000000,
                                   char_wait: 16'h0000, answer_limit: 16'h0000,
                                   first_limit: 8'h00, release_dly: 8'h70,
                                   ctrl: 8'h80, mask: 3'h0};

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [15:0]       idx;
  } cgw_aphase_s;

  typedef enum {RS_HOLD, RS_DELAY, RS_RUN} cgw_rst_e;

endpackage : cgw_pkg

// ---- design/cgw_timers.sv ----
// card guard and wait timers with ahb-lite register slave
module cgw_timers
  import cgw_pkg::*;
(
  // clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // character events
  input  wire logic              etu_tick,
  input  wire logic              rx_start,
  input  wire logic              break_det,
  input  wire logic              tx_req,
  output logic                   tx_go,
  // card side and interrupt
  output logic                   card_rst_n,
  output logic                   irq
);

  function automatic logic over_lim(input logic [27:0] cnt, input logic [27:0] lim);
    return cnt > lim;
  endfunction : over_lim

  function automatic logic [7:0] read_reg(input logic [15:0] idx, input cgw_cfg_s c,
                                          input logic [2:0] st);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_SPACING_MSB: v = {c.spacing[8], 7'h00};
      IDX_SPACING_LOW: v = c.spacing[7:0];
      IDX_BLOCK_B3:    v = {4'h0, c.block_wait[27:24]};
      IDX_BLOCK_B2:    v = c.block_wait[23:16];
      IDX_BLOCK_B1:    v = c.block_wait[15:8];
      IDX_BLOCK_B0:    v = c.block_wait[7:0];
      IDX_CHAR_HIGH:   v = c.char_wait[15:8];
      IDX_CHAR_LOW:    v = c.char_wait[7:0];
      IDX_ANSWER_HIGH: v = c.answer_limit[15:8];
      IDX_ANSWER_LOW:  v = c.answer_limit[7:0];
      IDX_FIRST_LIMIT: v = c.first_limit;
      IDX_RELEASE_DLY: v = c.release_dly;
      IDX_CTRL:        v = c.ctrl;
      IDX_STATUS:      v = {5'h00, st};
      IDX_MASK:        v = {5'h00, c.mask};
      default:         v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  cgw_cfg_s    cfg_r;
  cgw_cfg_s    cfg_nxt;
  cgw_aphase_s ap_r;
  cgw_aphase_s ap_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic [2:0]  status_r;
  logic [2:0]  status_nxt;
  logic [8:0]  sp_cnt_r;
  logic [8:0]  sp_cnt_nxt;
  logic [27:0] wt_cnt_r;
  logic [27:0] wt_cnt_nxt;
  logic        wt_run_r;
  logic        wt_run_nxt;
  logic [15:0] ch_cnt_r;
  logic [15:0] ch_cnt_nxt;
  logic        ch_run_r;
  logic        ch_run_nxt;
  logic [15:0] an_cnt_r;
  logic [15:0] an_cnt_nxt;
  logic        an_run_r;
  logic        an_run_nxt;
  logic        an_seen_r;
  logic        an_seen_nxt;
  logic [7:0]  fc_cnt_r;
  logic [7:0]  fc_cnt_nxt;
  logic        fc_run_r;
  logic        fc_run_nxt;
  logic [7:0]  rs_cnt_r;
  logic [7:0]  rs_cnt_nxt;
  cgw_rst_e    rs_state_r;
  cgw_rst_e    rs_state_nxt;
  logic        card_rst_n_r;
  logic        card_rst_n_nxt;

  logic        t1;
  logic        hold;
  logic [8:0]  space_req;
  logic        release_ev;
  logic        ev_wait;
  logic        ev_char;
  logic        ev_answer;
  logic [2:0]  st_clr;
  logic        addr_ok;

  assign t1         = cfg_r.ctrl[CTRL_T1_BIT];
  assign hold       = cfg_r.ctrl[CTRL_HOLD_BIT];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;
  assign card_rst_n = card_rst_n_r;
  assign irq        = |(status_r & cfg_r.mask);

  // register bus
  always_comb begin
    addr_ok    = (haddr[1:0] == 2'h0);
    ap_nxt     = '0;
    ap_nxt.valid = hsel && htrans[1] && hready && addr_ok;
    ap_nxt.write = hwrite;
    ap_nxt.idx   = haddr[ADDR_W-1:2];
    hrdata_nxt = hrdata_r;
    if (ap_nxt.valid && !hwrite) begin
      hrdata_nxt = {24'h000000, read_reg(ap_nxt.idx, cfg_r, status_r)};
    end
    cfg_nxt = cfg_r;
    st_clr  = 3'h0;
    if (ap_r.valid && ap_r.write) begin
      case (ap_r.idx)
        IDX_SPACING_MSB: cfg_nxt.spacing[8] = hwdata[SPACING_MSB_BIT];
        IDX_SPACING_LOW: cfg_nxt.spacing[7:0] = hwdata[7:0];
        IDX_BLOCK_B3:    cfg_nxt.block_wait[27:24] = hwdata[3:0];
        IDX_BLOCK_B2:    cfg_nxt.block_wait[23:16] = hwdata[7:0];
        IDX_BLOCK_B1:    cfg_nxt.block_wait[15:8] = hwdata[7:0];
        IDX_BLOCK_B0:    cfg_nxt.block_wait[7:0] = hwdata[7:0];
        IDX_CHAR_HIGH:   cfg_nxt.char_wait[15:8] = hwdata[7:0];
        IDX_CHAR_LOW:    cfg_nxt.char_wait[7:0] = hwdata[7:0];
        IDX_ANSWER_HIGH: cfg_nxt.answer_limit[15:8] = hwdata[7:0];
        IDX_ANSWER_LOW:  cfg_nxt.answer_limit[7:0] = hwdata[7:0];
        IDX_FIRST_LIMIT: cfg_nxt.first_limit = hwdata[7:0];
        IDX_RELEASE_DLY: cfg_nxt.release_dly = hwdata[7:0];
        IDX_CTRL:        cfg_nxt.ctrl = hwdata[7:0];
        IDX_STATUS:      st_clr = hwdata[ST_W-1:0];
        IDX_MASK:        cfg_nxt.mask = hwdata[ST_W-1:0];
        default:         cfg_nxt = cfg_r;
      endcase
    end
    // set wins over clear
    status_nxt = (status_r & ~st_clr) | {ev_answer, ev_char, ev_wait};
  end

  // tx start spacing
  always_comb begin
    space_req = t1 ? FLOOR_T1 : FLOOR_T0;
    if (cfg_r.spacing > space_req) begin
      space_req = cfg_r.spacing;
    end
    tx_go = clk_en && tx_req && (sp_cnt_r >= space_req) && !(!t1 && break_det);
    sp_cnt_nxt = sp_cnt_r;
    if (tx_go) begin
      sp_cnt_nxt = 9'h000;
    end else if (etu_tick && sp_cnt_r != SPACE_SAT) begin
      sp_cnt_nxt = sp_cnt_r + 9'h001;
    end
  end

  // block or work wait timer
  always_comb begin
    wt_cnt_nxt = wt_cnt_r;
    wt_run_nxt = wt_run_r;
    ev_wait    = 1'b0;
    if (t1 && rx_start) begin
      wt_run_nxt = 1'b0;
    end else if (tx_go || (!t1 && rx_start)) begin
      wt_run_nxt = 1'b1;
      wt_cnt_nxt = 28'h0000000;
    end else if (wt_run_r && etu_tick) begin
      wt_cnt_nxt = wt_cnt_r + 28'h0000001;
      if (over_lim(wt_cnt_nxt, cfg_r.block_wait)) begin
        ev_wait    = 1'b1;
        wt_run_nxt = 1'b0;
      end
    end
  end

  // character or initial wait timer
  always_comb begin
    ch_cnt_nxt = ch_cnt_r;
    ch_run_nxt = ch_run_r;
    ev_char    = 1'b0;
    if (rx_start) begin
      ch_run_nxt = 1'b1;
      ch_cnt_nxt = 16'h0000;
    end else if (ch_run_r && etu_tick) begin
      ch_cnt_nxt = ch_cnt_r + 16'h0001;
      if (over_lim({12'h000, ch_cnt_nxt}, {12'h000, cfg_r.char_wait})) begin
        ev_char    = 1'b1;
        ch_run_nxt = 1'b0;
      end
    end
  end

  // answer duration and first character timers
  always_comb begin
    an_cnt_nxt  = an_cnt_r;
    an_run_nxt  = an_run_r;
    an_seen_nxt = an_seen_r;
    fc_cnt_nxt  = fc_cnt_r;
    fc_run_nxt  = fc_run_r;
    ev_answer   = 1'b0;
    if (!cfg_r.ctrl[CTRL_ANSWER_BIT]) begin
      an_run_nxt  = 1'b0;
      an_seen_nxt = 1'b0;
    end else if (rx_start && !an_seen_r) begin
      an_run_nxt  = 1'b1;
      an_seen_nxt = 1'b1;
      an_cnt_nxt  = 16'h0000;
    end else if (an_run_r && etu_tick) begin
      an_cnt_nxt = an_cnt_r + 16'h0001;
      if (over_lim({12'h000, an_cnt_nxt}, {12'h000, cfg_r.answer_limit})) begin
        ev_answer  = 1'b1;
        an_run_nxt = 1'b0;
      end
    end
    if (hold || rx_start) begin
      fc_run_nxt = 1'b0;
    end else if (release_ev && cfg_r.ctrl[CTRL_DETECT_BIT]) begin
      fc_run_nxt = 1'b1;
      fc_cnt_nxt = 8'h00;
    end else if (fc_run_r && etu_tick) begin
      fc_cnt_nxt = fc_cnt_r + 8'h01;
      if (over_lim({20'h00000, fc_cnt_nxt}, {20'h00000, cfg_r.first_limit})) begin
        ev_answer  = 1'b1;
        fc_run_nxt = 1'b0;
      end
    end
  end

  // card reset release sequencing
  always_comb begin
    rs_state_nxt = rs_state_r;
    rs_cnt_nxt   = rs_cnt_r;
    release_ev   = 1'b0;
    case (rs_state_r)
      RS_HOLD: begin
        if (!hold) begin
          rs_cnt_nxt = 8'h00;
          if (cfg_r.release_dly == 8'h00) begin
            rs_state_nxt = RS_RUN;
            release_ev   = 1'b1;
          end else begin
            rs_state_nxt = RS_DELAY;
          end
        end
      end
      RS_DELAY: begin
        if (hold) begin
          rs_state_nxt = RS_HOLD;
        end else if (etu_tick) begin
          rs_cnt_nxt = rs_cnt_r + 8'h01;
          if (rs_cnt_nxt >= cfg_r.release_dly) begin
            rs_state_nxt = RS_RUN;
            release_ev   = 1'b1;
          end
        end
      end
      RS_RUN: begin
        if (hold) begin
          rs_state_nxt = RS_HOLD;
        end
      end
      default: rs_state_nxt = RS_HOLD;
    endcase
    card_rst_n_nxt = (rs_state_nxt == RS_RUN);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r        <= CFG_RST;
      ap_r         <= '0;
      hrdata_r     <= 32'h00000000;
      status_r     <= 3'h0;
      sp_cnt_r     <= SPACE_SAT;
      wt_cnt_r     <= 28'h0000000;
      wt_run_r     <= 1'b0;
      ch_cnt_r     <= 16'h0000;
      ch_run_r     <= 1'b0;
      an_cnt_r     <= 16'h0000;
      an_run_r     <= 1'b0;
      an_seen_r    <= 1'b0;
      fc_cnt_r     <= 8'h00;
      fc_run_r     <= 1'b0;
      rs_cnt_r     <= 8'h00;
      rs_state_r   <= RS_HOLD;
      card_rst_n_r <= 1'b0;
    end else if (clk_en) begin
      cfg_r        <= cfg_nxt;
      ap_r         <= ap_nxt;
      hrdata_r     <= hrdata_nxt;
      status_r     <= status_nxt;
      sp_cnt_r     <= sp_cnt_nxt;
      wt_cnt_r     <= wt_cnt_nxt;
      wt_run_r     <= wt_run_nxt;
      ch_cnt_r     <= ch_cnt_nxt;
      ch_run_r     <= ch_run_nxt;
      an_cnt_r     <= an_cnt_nxt;
      an_run_r     <= an_run_nxt;
      an_seen_r    <= an_seen_nxt;
      fc_cnt_r     <= fc_cnt_nxt;
      fc_run_r     <= fc_run_nxt;
      rs_cnt_r     <= rs_cnt_nxt;
      rs_state_r   <= rs_state_nxt;
      card_rst_n_r <= card_rst_n_nxt;
    end
  end

  // checks
  a_spacing_prog:
    assert property (@(posedge hclk) disable iff (!hresetn)
      tx_go |-> sp_cnt_r >= cfg_r.spacing)
    else $error("tx start before programmed spacing");

  a_spacing_floor:
    assert property (@(posedge hclk) disable iff (!hresetn)
      tx_go |-> sp_cnt_r >= (t1 ? FLOOR_T1 : FLOOR_T0))
    else $error("tx start below spacing floor");

  a_break_holds:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (!t1 && break_det) |-> !tx_go)
    else $error("tx start during t0 break");

  a_wait_exact:
    assert property (@(posedge hclk) disable iff (!hresetn)
      ev_wait |-> (wt_cnt_r >= cfg_r.block_wait) && etu_tick && wt_run_r)
    else $error("wait timeout at wrong count");

  a_work_rearm:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && !t1 && rx_start) |=> wt_run_r && (wt_cnt_r == 28'h0000000))
    else $error("work wait not restarted by rx edge");

  a_wait_sticky:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && ev_wait) |=> status_r[ST_WAIT] && (cfg_r.mask[ST_WAIT] -> irq))
    else $error("wait timeout not flagged");

  a_char_stop:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && ev_char) |=> status_r[ST_CHAR] && !ch_run_r)
    else $error("char timeout not flagged");

  a_answer_off:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && !cfg_r.ctrl[CTRL_ANSWER_BIT]) |=> !an_run_r && !an_seen_r)
    else $error("answer timer runs while disarmed");

  a_first_start:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && release_ev && cfg_r.ctrl[CTRL_DETECT_BIT] && !rx_start)
      |=> fc_run_r && (fc_cnt_r == 8'h00))
    else $error("first char timer not started");

  a_hold_reset:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && hold) |=> !card_rst_n)
    else $error("card reset released while held");

endmodule : cgw_timers

// ---- verification/cgw_card_model.sv ----
// card model: answers with start-bit events and can raise a break
module cgw_card_model (
  // clock and line events
  input  wire logic       hclk,
  input  wire logic       etu_tick,
  input  wire logic       card_rst_n,
  input  wire logic       tx_go,
  // behaviour controls
  input  wire logic       mute,
  input  wire logic [7:0] reply_etus,
  input  wire logic [7:0] brk_etus,
  // card outputs
  output logic            rx_start,
  output logic            break_det
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       rst_q;
  logic       armed;
  logic [7:0] cnt;
  logic [7:0] bcnt;
  initial begin
    rst_q = 1'b0;
    armed = 1'b0;
    cnt = 8'h00;
    rx_start = 1'b0;
    bcnt = 8'hff;
  end
  // break held for brk_etus ticks after each sent character
  assign break_det = bcnt < brk_etus;
  always @(posedge hclk) begin
    rst_q <= card_rst_n;
    rx_start <= 1'b0;
    if (tx_go)
      bcnt <= 8'h00;
    else if (etu_tick && bcnt != 8'hff)
      bcnt <= bcnt + 8'h01;
    if ((tx_go || (card_rst_n && !rst_q)) && !mute) begin
      armed <= 1'b1;
      cnt <= reply_etus;
    end else if (armed && etu_tick) begin
      if (cnt <= 8'h01) begin
        rx_start <= 1'b1;
        armed <= 1'b0;
      end else
        cnt <= cnt - 8'h01;
    end
  end
endmodule : cgw_card_model

// ---- verification/tb.sv ----
// self-checking bench of the card guard and wait timers
module tb import cgw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic              hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [ADDR_W-1:0] haddr;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       hwdata, hrdata;
  logic              etu_tick, rx_start, break_det, tx_req, tx_go;
  logic              card_rst_n, irq, mute, rd_ph;
  logic [7:0]        reply, brk, v;
  logic [31:0]       rdq[$];
  int                gapq[$];
  int                fails, tests_run, ticks, cyc;
  localparam logic [15:0] RI[13] = '{IDX_SPACING_LOW, IDX_BLOCK_B3, IDX_BLOCK_B2,
    IDX_BLOCK_B1, IDX_BLOCK_B0, IDX_CHAR_HIGH, IDX_CHAR_LOW, IDX_ANSWER_HIGH,
    IDX_ANSWER_LOW, IDX_FIRST_LIMIT, IDX_RELEASE_DLY, IDX_CTRL, 16'hfe1e};
  localparam logic [7:0] RV[13] = '{8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h70, 8'h80, 8'h00};
  int st1[6] = '{0, 1, 0, 1, 0, 1};
  int slo[6] = '{1, 1, 20, 0, 12, 12};
  int smb[6] = '{0, 0, 0, 1, 0, 0};
  int sbk[6] = '{0, 0, 0, 0, 20, 20};
  int sex[6] = '{12, 11, 20, 256, 20, 12};
  logic [7:0] wc[3] = '{8'h01, 8'h01, 8'h00};
  logic       wm[3] = '{1'b0, 1'b1, 1'b0};
  logic [7:0] we[3] = '{8'h00, 8'h01, 8'h01};

  cgw_timers DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .etu_tick(etu_tick), .rx_start(rx_start), .break_det(break_det),
    .tx_req(tx_req), .tx_go(tx_go), .card_rst_n(card_rst_n), .irq(irq));
  cgw_card_model card (.hclk(hclk), .etu_tick(etu_tick), .card_rst_n(card_rst_n),
    .tx_go(tx_go), .mute(mute), .reply_etus(reply), .brk_etus(brk),
    .rx_start(rx_start), .break_det(break_det));

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic bus(logic [15:0] idx, logic wr, logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'($urandom()), d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic wr(logic [15:0] idx, logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  task automatic rd(logic [15:0] idx, logic [7:0] e);
    rdq.push_back({24'h0, e});
    bus(idx, 1'b0, 8'h00);
  endtask : rd

  task automatic tx_once();
    @(posedge hclk);
    tx_req <= 1'b1;
    do @(posedge hclk); while (tx_go !== 1'b1);
    tx_req <= 1'b0;
  endtask : tx_once

  task automatic etus(int n);
    repeat (n) do @(posedge hclk); while (etu_tick !== 1'b1);
  endtask : etus

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    etu_tick = 1'b0;
    @(posedge hresetn);
    forever begin
      repeat (3 + $urandom_range(3)) @(posedge hclk);
      etu_tick <= 1'b1;
      @(posedge hclk);
      etu_tick <= 1'b0;
    end
  end

  // read data and character spacing watcher
  always @(posedge hclk) begin
    if (rd_ph && rdq.size() > 0)
      chk("hrdata", rdq.pop_front(), hrdata);
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
    if (tx_go === 1'b1) begin
      if (gapq.size() > 0)
        chk("gap", 32'(gapq.pop_front()), 32'(ticks));
      ticks = 0;
    end else if (etu_tick)
      ticks++;
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'h9131c5fb));
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, tx_req, brk} = '0;
    {fails, tests_run} = '0;
    clk_en = 1'b1;
    hsize = 3'h2;
    mute = 1'b1;
    reply = 8'h03;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk) chk("card_rst_n", 0, card_rst_n);
    for (int i = 0; i < 13; i++)
      rd(RI[i], RV[i]);
    wr(16'hfe1e, 8'hff);
    rd(16'hfe1e, 8'h00);
    wr(IDX_SPACING_MSB, 8'hff);
    rd(IDX_SPACING_MSB, 8'h80);
    for (int i = 0; i < 4; i++)
      wr(IDX_BLOCK_B3 + 16'(i), 8'hff);
    rd(IDX_BLOCK_B3, 8'h0f);
    v = 8'($urandom());
    wr(IDX_CHAR_HIGH, v);
    rd(IDX_CHAR_HIGH, v);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CTRL, 8'(8'h80 | st1[i]));
      wr(IDX_SPACING_LOW, 8'(slo[i]));
      wr(IDX_SPACING_MSB, 8'(smb[i] << 7));
      brk <= 8'(sbk[i]);
      tx_once();
      @(negedge hclk) gapq.push_back(sex[i]);
      tx_once();
      brk <= 8'h00;
    end
    wr(IDX_SPACING_MSB, 8'h00);
    wr(IDX_SPACING_LOW, 8'h0c);
    wr(IDX_RELEASE_DLY, 8'h02);
    wr(IDX_FIRST_LIMIT, 8'h05);
    wr(IDX_STATUS, 8'h07);
    wr(IDX_CTRL, 8'h04);
    etus(1);
    @(negedge hclk) chk("card_rst_n", 0, card_rst_n);
    etus(2);
    @(negedge hclk) chk("card_rst_n", 1, card_rst_n);
    etus(8);
    rd(IDX_STATUS, 8'h04);
    @(negedge hclk) chk("irq", 0, irq);
    wr(IDX_MASK, 8'h04);
    @(negedge hclk) chk("irq", 1, irq);
    wr(IDX_STATUS, 8'h04);
    @(negedge hclk) chk("irq", 0, irq);
    wr(IDX_CTRL, 8'h84);
    @(posedge hclk);
    @(negedge hclk) chk("card_rst_n", 0, card_rst_n);
    mute <= 1'b0;
    wr(IDX_CHAR_HIGH, 8'h00);
    wr(IDX_CHAR_LOW, 8'h04);
    wr(IDX_STATUS, 8'h07);
    wr(IDX_CTRL, 8'h04);
    etus(14);
    rd(IDX_STATUS, 8'h02);
    @(negedge hclk) chk("irq", 0, irq);
    wr(IDX_CHAR_HIGH, 8'hff);
    wr(IDX_CHAR_LOW, 8'hff);
    wr(IDX_ANSWER_LOW, 8'h03);
    wr(IDX_CTRL, 8'h82);
    reply <= 8'h01;
    wr(IDX_STATUS, 8'h07);
    wr(IDX_CTRL, 8'h02);
    etus(12);
    rd(IDX_STATUS, 8'h04);
    @(negedge hclk) chk("irq", 1, irq);
    @(posedge hclk) clk_en <= 1'b0;
    wr(IDX_STATUS, 8'h07);
    @(posedge hclk) clk_en <= 1'b1;
    @(negedge hclk) chk("irq", 1, irq);
    reply <= 8'h03;
    for (int i = 0; i < 4; i++)
      wr(IDX_BLOCK_B3 + 16'(i), i == 3 ? 8'h06 : 8'h00);
    for (int i = 0; i < 3; i++) begin
      mute <= wm[i];
      wr(IDX_CTRL, wc[i]);
      tx_once();
      etus(12);
      wr(IDX_STATUS, 8'h07);
      tx_once();
      etus(12);
      rd(IDX_STATUS, we[i]);
    end
    repeat (3) @(posedge hclk);
    end_of_test();
  end
endmodule : tb
